// >>> fcf_flash_model.sv
// flash side byte stream model for the control-code fifo port
`timescale 1ns/1ps
module fcf_flash_model (
  // clock, reset and stall control
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic stall_in,
  // outbound bytes from the port
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // inbound bytes towards the port
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  // accept outbound bytes unless stalled
  assign tx_ready_out = !stall_in;
  // log outbound bytes in wire order, offer inbound ones
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
    end
    else
    begin
      if (tx_valid_in && tx_ready_out)
        got_q.push_back(tx_data_in);
      if (rx_valid_out && rx_ready_in)
        void'(send_q.pop_front());
      // idle lines flip so a stale byte never looks valid
      rx_valid_out <= send_q.size() != 0 && !stall_in;
      rx_data_out <= send_q.size() != 0 ? send_q[0] : ~rx_data_out;
    end
  end
endmodule

// >>> fcf_pkg.sv
// constants for the control-code fifo port block
package fcf_pkg;
  // register byte addresses on the avalon slave
  localparam logic [3:0] FCF_ADDR_PORT = 4'h0;
  localparam logic [3:0] FCF_ADDR_CTRL = 4'h4;
  localparam logic [3:0] FCF_ADDR_STAT = 4'h8;
  // control register fields
  localparam int FCF_CTRL_DIR_BIT = 0;
  localparam int FCF_CTRL_CLR_BIT = 1;
  // status register fields
  localparam int FCF_STAT_CNT_LSB = 0;
  localparam int FCF_STAT_EMPTY_BIT = 8;
  localparam int FCF_STAT_FULL_BIT = 9;
  localparam int FCF_STAT_ERR_BIT = 10;
  // fifo geometry: 16 words of 32 bits
  localparam int FCF_DEPTH = 16;
  localparam int FCF_AW = 4;
  // values after reset
  localparam logic [31:0] FCF_RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] FCF_RESET_CNT = 5'h00;
  localparam logic [1:0] FCF_RESET_LANE = 2'h0;
  // direction codes for transfer_direction_select
  localparam logic FCF_DIR_READ = 1'b0;
  localparam logic FCF_DIR_WRITE = 1'b1;
endpackage

// >>> fcf_port.sv
// control-code fifo port with avalon slave and flash byte stream
`timescale 1ns/1ps
module fcf_port
  import fcf_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // flash byte stream, outbound
  output logic [7:0] flash_tx_data_out,
  output logic flash_tx_valid_out,
  input wire logic flash_tx_ready_in,
  // flash byte stream, inbound
  input wire logic [7:0] flash_rx_data_in,
  input wire logic flash_rx_valid_in,
  output logic flash_rx_ready_out
);

  // fifo storage, pointers and lane state
  logic [31:0] mem_reg [FCF_DEPTH];
  logic [FCF_AW-1:0] wr_ptr_reg;
  logic [FCF_AW-1:0] rd_ptr_reg;
  logic [4:0] count_reg;
  logic dir_reg;
  logic err_reg;
  logic [1:0] tx_lane_reg;
  logic [1:0] rx_lane_reg;
  logic [23:0] rx_acc_reg;
  logic [31:0] readdata_reg;
  // decode, handshake and word-boundary terms
  logic full;
  logic empty;
  logic sel_port;
  logic sel_ctrl;
  logic sel_stat;
  logic port_push;
  logic port_pop;
  logic tx_word_done;
  logic rx_word_done;
  logic do_push;
  logic do_pop;
  logic clear;
  logic [31:0] rx_word;
  logic reg_rd_fresh_reg;

  // byte of a word by lane, lane 0 is the top byte
  function automatic logic [7:0] lane_byte(input logic [31:0] w,
                                           input logic [1:0] lane);
    logic [7:0] b;
    b = 8'h00;
    unique case (lane)
      2'd0: b = w[31:24];
      2'd1: b = w[23:16];
      2'd2: b = w[15:8];
      2'd3: b = w[7:0];
    endcase
    return b;
  endfunction

  // address decode
  assign sel_port = (address_in == FCF_ADDR_PORT);
  assign sel_ctrl = (address_in == FCF_ADDR_CTRL);
  assign sel_stat = (address_in == FCF_ADDR_STAT);
  assign full = (count_reg == 5'(FCF_DEPTH));
  assign empty = (count_reg == FCF_RESET_CNT);
  assign clear = write_in && sel_ctrl
      && writedata_in[FCF_CTRL_CLR_BIT];

  // port stalls while fifo cannot take or give a word
  always_comb
  begin
    waitrequest_out = 1'b0;
    if (sel_port && write_in && dir_reg == FCF_DIR_WRITE && full)
      waitrequest_out = 1'b1;
    if (sel_port && read_in && dir_reg == FCF_DIR_READ && empty)
      waitrequest_out = 1'b1;
    // register words are one edge old, so hold the master one edge
    if (read_in && (sel_ctrl || sel_stat) && !reg_rd_fresh_reg)
      waitrequest_out = 1'b1;
  end

  // set for the edge after a register read was first seen
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rd_fresh_reg <= 1'b0;
    else
      reg_rd_fresh_reg <= read_in && (sel_ctrl || sel_stat)
          && !reg_rd_fresh_reg;
  end

  // accepted port accesses in the selected direction
  assign port_push = write_in && sel_port && !waitrequest_out
      && dir_reg == FCF_DIR_WRITE;
  assign port_pop = read_in && sel_port && !waitrequest_out
      && dir_reg == FCF_DIR_READ;
  assign tx_word_done = flash_tx_valid_out && flash_tx_ready_in
      && tx_lane_reg == 2'd3;
  assign rx_word_done = flash_rx_valid_in && flash_rx_ready_out
      && rx_lane_reg == 2'd3;
  assign do_push = port_push || rx_word_done;
  assign do_pop = port_pop || tx_word_done;
  assign rx_word = {rx_acc_reg, flash_rx_data_in};

  // fifo storage, one writer per direction
  always_ff @(posedge clock_in)
  begin
    if (do_push && !clear)
      mem_reg[wr_ptr_reg] <= port_push ? writedata_in : rx_word;
  end

  // pointers and fill count, clear discards everything
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= FCF_RESET_CNT;
    end
    else if (clear)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= FCF_RESET_CNT;
    end
    else
    begin
      if (do_push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (do_push && !do_pop)
        count_reg <= count_reg + 1'b1;
      else if (do_pop && !do_push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // direction and misuse flag; a new misuse beats the clear
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dir_reg <= FCF_DIR_READ;
      err_reg <= 1'b0;
    end
    else
    begin
      if (write_in && sel_ctrl)
        dir_reg <= writedata_in[FCF_CTRL_DIR_BIT];
      if ((write_in && sel_port && dir_reg != FCF_DIR_WRITE)
          || (read_in && sel_port && dir_reg != FCF_DIR_READ))
        err_reg <= 1'b1;
      else if (write_in && sel_stat && writedata_in[FCF_STAT_ERR_BIT])
        err_reg <= 1'b0;
    end
  end

  // outbound serialiser, top byte first
  // a word read back through the port restarts the outbound lane
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tx_lane_reg <= FCF_RESET_LANE;
    else if (clear)
      tx_lane_reg <= FCF_RESET_LANE;
    else if (port_pop)
      tx_lane_reg <= FCF_RESET_LANE;
    else if (flash_tx_valid_out && flash_tx_ready_in)
      tx_lane_reg <= tx_lane_reg + 1'b1;
  end

  assign flash_tx_valid_out = (dir_reg == FCF_DIR_WRITE) && !empty
      && !clear;

  // head byte shows while idle; valid qualifies it
  always_comb
  begin
    flash_tx_data_out = lane_byte(mem_reg[rd_ptr_reg],
                                  tx_lane_reg);
  end

  // inbound assembler, first byte lands in bits 31:24
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_lane_reg <= FCF_RESET_LANE;
      rx_acc_reg <= '0;
    end
    else if (clear)
      rx_lane_reg <= FCF_RESET_LANE; // partial word dropped
    else if (flash_rx_valid_in && flash_rx_ready_out)
    begin
      rx_lane_reg <= rx_lane_reg + 1'b1;
      rx_acc_reg <= {rx_acc_reg[15:0], flash_rx_data_in};
    end
  end

  assign flash_rx_ready_out = (dir_reg == FCF_DIR_READ) && !full
      && !clear;

  // read data register, port word taken from fifo head
  always_comb
  begin
    readdata_out = readdata_reg;
    if (sel_port)
      readdata_out = (dir_reg == FCF_DIR_READ && !empty)
          ? mem_reg[rd_ptr_reg] : FCF_RESET_WORD;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      readdata_reg <= FCF_RESET_WORD;
    else
    begin
      readdata_reg <= FCF_RESET_WORD;
      if (sel_ctrl)
        readdata_reg[FCF_CTRL_DIR_BIT] <= dir_reg;
      else if (sel_stat)
      begin
        readdata_reg[FCF_STAT_CNT_LSB +: 5] <= count_reg;
        readdata_reg[FCF_STAT_EMPTY_BIT] <= empty;
        readdata_reg[FCF_STAT_FULL_BIT] <= full;
        readdata_reg[FCF_STAT_ERR_BIT] <= err_reg;
      end
    end
  end

  // checks
  a_clear_empties: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) clear |=> (count_reg == 5'd0))
    else $error("fifo not empty after clear");
  a_push_counts: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (port_push && !clear && !do_pop)
    |=> count_reg == $past(count_reg) + 5'd1)
    else $error("port write did not add a word");
  a_pop_counts: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (port_pop && !clear && !rx_word_done)
    |=> count_reg == $past(count_reg) - 5'd1)
    else $error("port read did not remove a word");
  a_wrong_dir_err: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (sel_port && write_in && dir_reg == FCF_DIR_READ)
    |=> err_reg)
    else $error("misdirected access not flagged");
  a_first_byte_top: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (port_push && empty && !clear)
    |=> clear || flash_tx_data_out == $past(writedata_in[31:24]))
    else $error("first byte not from bits 31 to 24");
  a_lane_order: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (flash_tx_valid_out && flash_tx_ready_in
    && !clear) |=> tx_lane_reg == $past(tx_lane_reg) + 2'd1)
    else $error("byte lane did not advance");
  a_tx_dir_only: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) flash_tx_valid_out |-> dir_reg == FCF_DIR_WRITE
    && !flash_rx_ready_out)
    else $error("outbound bytes while reading");
  a_rx_word_lands: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (rx_word_done && !clear && !port_pop)
    |=> count_reg == $past(count_reg) + 5'd1)
    else $error("captured word not stored");
  a_misuse_no_pop: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (sel_port && read_in && dir_reg == FCF_DIR_WRITE
    && !tx_word_done) |=> count_reg == $past(count_reg))
    else $error("misdirected read removed a word");
  a_misuse_no_push: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (sel_port && write_in && dir_reg == FCF_DIR_READ
    && !rx_word_done) |=> count_reg == $past(count_reg))
    else $error("misdirected write added a word");

  // flash side checks
  a_clear_lanes: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) clear |=> tx_lane_reg == FCF_RESET_LANE
    && rx_lane_reg == FCF_RESET_LANE)
    else $error("byte lanes not reset by clear");
  a_tx_lane_hold: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (flash_tx_valid_out && !flash_tx_ready_in)
    |=> tx_lane_reg == $past(tx_lane_reg))
    else $error("outbound lane moved while flash stalled");
  a_rx_lane_hold: assert property (@(posedge clock_in)
    disable iff (!rst_n_in) (flash_rx_ready_out && !flash_rx_valid_in)
    |=> rx_lane_reg == $past(rx_lane_reg))
    else $error("inbound lane moved without a byte");
  a_rx_dir_only: assert property (@(posedge clock_in)
    disable iff (!rst_n_in)
    flash_rx_ready_out |-> dir_reg == FCF_DIR_READ)
    else $error("inbound bytes taken while writing");
endmodule

// >>> test_flash_control_code_fifo_port.sv
// self-checking bench for the control-code fifo port
`timescale 1ns/1ps
module test_flash_control_code_fifo_port;
  import fcf_pkg::*;
  logic clock_in = 0, rst_n_in = 0, read_in = 0, write_in = 0;
  logic [3:0] address_in = 4'h0;
  logic [31:0] writedata_in = 32'h0000_0000, readdata_out, q, w;
  logic waitrequest_out, tx_valid, tx_ready, rx_valid, rx_ready;
  logic stall = 1, hold = 1;
  logic [7:0] tx_data, rx_data;
  logic [31:0] seed = 32'h0001_3B31;
  logic [31:0] exp_q[$];
  logic [7:0] b_q[$];
  int n_mismatch = 0, compares = 0, cyc = 0;
  fcf_port u_fcf_port (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .flash_tx_data_out(tx_data),
    .flash_tx_valid_out(tx_valid), .flash_tx_ready_in(tx_ready),
    .flash_rx_data_in(rx_data), .flash_rx_valid_in(rx_valid),
    .flash_rx_ready_out(rx_ready));
  fcf_flash_model u_fcf_flash_model (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .stall_in(stall), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready));
  // 40 MHz clock
  initial forever #12.5 clock_in = ~clock_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected status word from a fill count and the misuse flag
  function automatic logic [31:0] stat_word(input int cnt, input logic err);
    stat_word = '0;
    stat_word[FCF_STAT_CNT_LSB +: 5] = 5'(cnt);
    stat_word[FCF_STAT_EMPTY_BIT] = (cnt == 0);
    stat_word[FCF_STAT_FULL_BIT] = (cnt == FCF_DEPTH);
    stat_word[FCF_STAT_ERR_BIT] = err;
  endfunction
  // one avalon transfer: request rises with address and data after an
  // edge, stands until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    address_in <= a;
    writedata_in <= d;
    write_in <= wr;
    read_in <= !wr;
    do @(posedge clock_in); while (waitrequest_out !== 1'b0);
    r = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // random far-side stalls and the hang limit
  always @(posedge clock_in)
  begin
    stall <= hold | (rnd() % 4 == 0);
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_n_in <= 1'b1;
    @(posedge clock_in);
    // reset state, clear before use, then accesses against the direction
    bus(0, FCF_ADDR_STAT, 0, q);
    check("stat", q, stat_word(0, 0));
    bus(1, FCF_ADDR_CTRL, 32'h0000_0002, q);
    bus(1, FCF_ADDR_PORT, rnd(), q);
    bus(0, FCF_ADDR_STAT, 0, q);
    check("err_wr", q, stat_word(0, 1));
    bus(1, FCF_ADDR_STAT, 32'h0000_0400, q);
    bus(1, FCF_ADDR_CTRL, 32'h0000_0003, q);
    bus(0, FCF_ADDR_CTRL, 0, q);
    check("ctrl", q, 32'h0000_0001);
    bus(0, FCF_ADDR_PORT, 0, q);
    check("port", q, 32'h0000_0000);
    bus(0, FCF_ADDR_STAT, 0, q);
    check("err_rd", q, stat_word(0, 1));
    bus(1, FCF_ADDR_STAT, 32'h0000_0400, q);
    $display("test reset done");
    // clear throws away words the stalled flash never took
    repeat (3) bus(1, FCF_ADDR_PORT, rnd(), q);
    bus(0, FCF_ADDR_STAT, 0, q);
    check("count", q, stat_word(3, 0));
    bus(1, FCF_ADDR_CTRL, 32'h0000_0003, q);
    bus(0, FCF_ADDR_STAT, 0, q);
    check("clear", q, stat_word(0, 0));
    hold <= 1'b0;
    repeat (10) @(posedge clock_in);
    check("drop", 32'(u_fcf_flash_model.got_q.size()), 0);
    $display("test clear done");
    // write direction: fill to full with the flash held, then drain
    hold <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      if (i == FCF_DEPTH)
      begin
        bus(0, FCF_ADDR_STAT, 0, q);
        check("full", q, stat_word(FCF_DEPTH, 0));
        hold <= 1'b0;
      end
      exp_q.push_back(rnd());
      bus(1, FCF_ADDR_PORT, exp_q[i], q);
    end
    for (int i = 0; i < 400 && u_fcf_flash_model.got_q.size() < 80; i++)
      @(posedge clock_in);
    check("bytes", 32'(u_fcf_flash_model.got_q.size()), 80);
    for (int i = 0; i < 20; i++)
      check("tx", {u_fcf_flash_model.got_q[4*i],
        u_fcf_flash_model.got_q[4*i+1], u_fcf_flash_model.got_q[4*i+2],
        u_fcf_flash_model.got_q[4*i+3]}, exp_q[i]);
    $display("test write done");
    // read direction, bytes gathered first byte high
    bus(1, FCF_ADDR_CTRL, 32'h0000_0002, q);
    bus(0, FCF_ADDR_CTRL, 0, q);
    check("ctrl_rd", q, 32'h0000_0000);
    for (int i = 0; i < 48; i++)
    begin
      w = rnd();
      b_q.push_back(w[7:0]);
      u_fcf_flash_model.send_q.push_back(w[7:0]);
    end
    for (int i = 0; i < 12; i++)
    begin
      bus(0, FCF_ADDR_PORT, 0, q);
      check("rx", q, {b_q[4*i], b_q[4*i+1], b_q[4*i+2],
        b_q[4*i+3]});
    end
    $display("test read done");
    stop_test();
  end
endmodule
